/* File: verilog/pbc_control_reg.sv */
// Per-port basic control register with pin-latched defaults.
// Assumes the management interface delivers decoded write/read strobes.
//
// Functional notes
// - Negotiation-enable bit runs auto-negotiation.
// - Power-down bit powers the port down.
// - Isolate bit disconnects MAC side, resets zero.
// - Restart bit restarts negotiation only while negotiation is enabled, then self-clears.
// - Duplex bit selects full or half duplex.
// - Loopback bit routes port into internal loopback.
// - Latched bits default from pins at hardware reset.
// - Software reset restores last hardware-latched values.
`timescale 1ns/100ps
`default_nettype none
module pbc_control_reg
  import pbc_pkg::*;
(
  input  wire logic                clk,      // Management clock
  input  wire logic                sys_rst,  // Hardware reset, active high
  input  wire pbc_pkg::pbc_straps_s strapPins, // Configuration pins
  input  wire logic                wrEn,     // Write strobe
  input  wire logic                rdEn,     // Read strobe
  input  wire logic [4:0]          regAddr,  // Register address
  input  wire logic [15:0]         wrData,   // Write data
  output logic [15:0]              rdData_ff, // Read data
  output logic                     rdValid_ff, // Read data valid
  output var pbc_pkg::pbc_ctrl_s   ctrl_ff   // Controls to datapath
);
  import pbc_pkg::*;

  pbc_straps_s latched_ff;   // Values captured at hardware reset
  logic        capture_ff;   // Capture pending after reset release
  logic        swRst_ff;     // Software reset in progress
  logic        loop_ff, spdHi_ff, spdLo_ff, anEn_ff;
  logic        pwrDn_ff, iso_ff, rstrt_ff, dup_ff;
  logic        hit;          // Address match
  logic        restartReq;   // Restart requested this cycle
  logic        seqActive;
  logic        seqDone;

  assign hit = (regAddr == PbcCtrlAddr);
  // Restart requested by writing one to the restart bit; a write that the
  // capture or soft-reset cycle refuses must not start the sequencer either
  assign restartReq = wrEn && hit && wrData[BitAnRestart] && !capture_ff && !swRst_ff;

  // Pins are caught by a clocked process one edge after release
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      capture_ff <= 1'h1;
    else if (capture_ff)
    begin
      latched_ff <= strapPins;
      capture_ff <= 1'h0;
    end
  end

  // Control bits; hardware reset holds defaults until pins are caught
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      loop_ff  <= ResetLoopback;
      spdHi_ff <= ResetSpeedHi;
      iso_ff   <= ResetIsolate;
      spdLo_ff <= 1'h0;
      anEn_ff  <= 1'h0;
      pwrDn_ff <= 1'h0;
      dup_ff   <= 1'h0;
      swRst_ff <= 1'h0;
    end
    else if (capture_ff)
    begin
      // First edge after release: load straps straight from pins
      spdLo_ff <= strapPins.speedLo;
      anEn_ff  <= strapPins.anEnable;
      pwrDn_ff <= strapPins.powerDown;
      dup_ff   <= strapPins.duplex;
    end
    else if (swRst_ff)
    begin
      // Pins are not resampled; restore the captured copy
      loop_ff  <= ResetLoopback;
      spdHi_ff <= ResetSpeedHi;
      iso_ff   <= ResetIsolate;
      spdLo_ff <= latched_ff.speedLo;
      anEn_ff  <= latched_ff.anEnable;
      pwrDn_ff <= latched_ff.powerDown;
      dup_ff   <= latched_ff.duplex;
      swRst_ff <= 1'h0;
    end
    else if (wrEn && hit)
    begin
      // Reserved bits are dropped; values read back as stored
      swRst_ff <= wrData[BitSwReset];
      loop_ff  <= wrData[BitLoopback];
      spdHi_ff <= wrData[BitSpeedHi];
      spdLo_ff <= wrData[BitSpeedLo];
      anEn_ff  <= wrData[BitAnEnable];
      pwrDn_ff <= wrData[BitPowerDown];
      iso_ff   <= wrData[BitIsolate];
      dup_ff   <= wrData[BitDuplex];
    end
  end

  // Self-clearing restart bit; a new request wins over completion
  always_ff @(posedge clk)
  begin
    if (sys_rst || swRst_ff)
      rstrt_ff <= ResetRestart;
    else if (restartReq)
      rstrt_ff <= 1'h1;
    else if (seqDone)
      rstrt_ff <= 1'h0;
  end

  pbc_restart_seq u_seq (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .startReq (restartReq),
    .active   (seqActive),
    .doneP    (seqDone)
  );

  // Controls take effect on the edge after the register updates
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl_ff <= '0;
    else
    begin
      ctrl_ff.loopback   <= loop_ff;
      ctrl_ff.speed100   <= ({spdHi_ff, spdLo_ff} == SpeedSel100);
      ctrl_ff.anEnable   <= anEn_ff;
      ctrl_ff.anRestart  <= anEn_ff && seqActive;
      ctrl_ff.powerDown  <= pwrDn_ff;
      ctrl_ff.isolate    <= iso_ff;
      ctrl_ff.fullDuplex <= dup_ff;
    end
  end

  // Read port: one cycle after the strobe; unmapped address reads zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdData_ff  <= '0;
      rdValid_ff <= 1'h0;
    end
    else
    begin
      rdValid_ff <= rdEn;
      rdData_ff  <= '0;
      if (rdEn && hit)
      begin
        rdData_ff[BitSwReset]   <= swRst_ff;
        rdData_ff[BitLoopback]  <= loop_ff;
        rdData_ff[BitSpeedLo]   <= spdLo_ff;
        rdData_ff[BitAnEnable]  <= anEn_ff;
        rdData_ff[BitPowerDown] <= pwrDn_ff;
        rdData_ff[BitIsolate]   <= iso_ff;
        rdData_ff[BitAnRestart] <= rstrt_ff;
        rdData_ff[BitDuplex]    <= dup_ff;
        rdData_ff[BitSpeedHi]   <= spdHi_ff;
      end
    end
  end

  // Assertions
  property p_iso_follow;
    @(posedge clk) disable iff (sys_rst) $rose(iso_ff) |=> ctrl_ff.isolate;
  endproperty
  a_iso_follow: assert property (p_iso_follow) else $error("isolate not applied");

  property p_speed;
    @(posedge clk) disable iff (sys_rst)
      ({spdHi_ff, spdLo_ff} == SpeedSel10) |=> !ctrl_ff.speed100;
  endproperty
  a_speed: assert property (p_speed) else $error("speed decode wrong");

  property p_restart_clear;
    @(posedge clk) disable iff (sys_rst || swRst_ff)
      restartReq ##1 !restartReq [*6] |-> ##[0:2] !rstrt_ff;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart not self-cleared");

  property p_restart_set;
    @(posedge clk) disable iff (sys_rst) restartReq && !swRst_ff |=> rstrt_ff;
  endproperty
  a_restart_set: assert property (p_restart_set) else $error("restart not set");

  property p_swrst_restore;
    @(posedge clk) disable iff (sys_rst)
      swRst_ff && !capture_ff |=> (dup_ff == $past(latched_ff.duplex)) && !iso_ff;
  endproperty
  a_swrst_restore: assert property (p_swrst_restore) else $error("soft reset restore wrong");

  property p_strap;
    @(posedge clk) $fell(sys_rst) |=> (anEn_ff == $past(strapPins.anEnable));
  endproperty
  a_strap: assert property (p_strap) else $error("strap not latched");

  property p_dup;
    @(posedge clk) disable iff (sys_rst)
      wrEn && hit && !swRst_ff && !capture_ff |=> ##1 ctrl_ff.fullDuplex == $past(wrData[BitDuplex], 2);
  endproperty
  a_dup: assert property (p_dup) else $error("duplex not applied");

  property p_pwr;
    @(posedge clk) disable iff (sys_rst) pwrDn_ff |=> ctrl_ff.powerDown;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-down not applied");

  property p_read;
    @(posedge clk) disable iff (sys_rst)
      rdEn && hit |=> rdValid_ff && rdData_ff[BitLoopback] == $past(loop_ff);
  endproperty
  a_read: assert property (p_read) else $error("readback mismatch");

endmodule // pbc_control_reg
`default_nettype wire

/* File: shared/pbc_pkg.sv */
// Package for the per-port basic control register block.
// Assumes a single 100 MHz management-side clock and synchronous reset.
package pbc_pkg;

  // Bit positions inside the 16-bit control word
  localparam int unsigned BitSwReset   = 15;
  localparam int unsigned BitLoopback  = 14;
  localparam int unsigned BitSpeedLo   = 13;
  localparam int unsigned BitAnEnable  = 12;
  localparam int unsigned BitPowerDown = 11;
  localparam int unsigned BitIsolate   = 10;
  localparam int unsigned BitAnRestart = 9;
  localparam int unsigned BitDuplex    = 8;
  localparam int unsigned BitSpeedHi   = 6;

  localparam int unsigned RegWidth = 16;

  // Register address of the control word on the management port
  localparam logic [4:0] PbcCtrlAddr = 5'h00;

  // Reset values of bits that are not pin latched
  localparam logic ResetLoopback = 1'h0;
  localparam logic ResetIsolate  = 1'h0;
  localparam logic ResetRestart  = 1'h0;
  localparam logic ResetSpeedHi  = 1'h0;

  // Speed pair {hi,lo}
  localparam logic [1:0] SpeedSel10  = 2'h0;
  localparam logic [1:0] SpeedSel100 = 2'h1;

  // Cycles the restart pulse is held before the bit self-clears
  localparam int unsigned RestartCycles = 4;
  localparam logic [2:0]  RestartLast   = 3'h3;
  localparam logic [2:0]  CountZero     = 3'h0;
  localparam logic [2:0]  CountOne      = 3'h1;

  // Pin-latched defaults
  typedef struct packed {
    logic speedLo;
    logic anEnable;
    logic powerDown;
    logic duplex;
  } pbc_straps_s;

  // Port controls driven into the datapath
  typedef struct packed {
    logic loopback;
    logic speed100;
    logic anEnable;
    logic anRestart;
    logic powerDown;
    logic isolate;
    logic fullDuplex;
  } pbc_ctrl_s;

  // Restart sequencer states
  typedef enum logic [1:0] {PBC_IDLE, PBC_RUN} pbc_rst_e;

endpackage : pbc_pkg

/* File: verilog/pbc_restart_seq.sv */
// Restart sequencer: turns a restart request into a fixed-length pulse
// and reports completion so the control bit can self-clear.
// Assumes the request is a one-cycle pulse in the clk domain.
`timescale 1ns/100ps
`default_nettype none
module pbc_restart_seq
  import pbc_pkg::*;
(
  input  wire logic clk,      // Management clock
  input  wire logic sys_rst,  // Synchronous reset, active high
  input  wire logic startReq, // Restart request pulse
  output logic      active,   // Restart in progress
  output logic      doneP     // One-cycle completion pulse
);
  pbc_rst_e   state_ff;  // Sequencer state
  logic [2:0] cnt_ff;    // Cycles spent restarting

  // Sequencer; a new request during a run restarts the count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_ff <= PBC_IDLE;
      cnt_ff   <= CountZero;
      doneP    <= 1'h0;
    end
    else
    begin
      doneP <= 1'h0;
      unique case (state_ff)
        PBC_IDLE:
        begin
          if (startReq)
          begin
            state_ff <= PBC_RUN;
            cnt_ff   <= CountZero;
          end
        end
        PBC_RUN:
        begin
          if (startReq)
            cnt_ff <= CountZero;
          else if (cnt_ff == RestartLast)
          begin
            state_ff <= PBC_IDLE;
            doneP    <= 1'h1;
          end
          else
            cnt_ff <= cnt_ff + CountOne;
        end
      endcase
    end
  end

  assign active = (state_ff == PBC_RUN);
endmodule // pbc_restart_seq
`default_nettype wire

/* File: tb/pbc_station_model.sv */
// Station-side model of the management master for the control register.
// Assumes the register's timing: one-cycle strobes, read data one cycle later.
`timescale 1ns/100ps
`default_nettype none
module pbc_station_model
  import pbc_pkg::*;
(
  input  wire logic        clk,        // Management clock
  output logic             wrEn,       // Write strobe
  output logic             rdEn,       // Read strobe
  output logic [4:0]       regAddr,    // Register address
  output logic [15:0]      wrData,     // Write data
  input  wire logic [15:0] rdData_ff,  // Read data
  input  wire logic        rdValid_ff  // Read data valid
);
  // Quiet bus at time zero
  initial
  begin
    wrEn = 1'h0;
    rdEn = 1'h0;
    regAddr = 5'h1f;
    wrData = 16'h0;
  end

  // One write; released lines show the inverse so stale data never looks valid
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    regAddr = a;
    wrData = d;
    wrEn = 1'h1;
    @(posedge clk);
    #1;
    wrEn = 1'h0;
    regAddr = ~a;
    wrData = ~d;
  endtask

  // One read; the answer stands one cycle, so it is taken right after the edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    #1;
    regAddr = a;
    rdEn = 1'h1;
    @(posedge clk);
    #1;
    rdEn = 1'h0;
    regAddr = ~a;
    v = rdValid_ff;
    d = rdData_ff;
  endtask
endmodule // pbc_station_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the basic control register.
// Assumes pbc_pkg and the station model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import pbc_pkg::*;
  logic        clk = 1'h0;     // Management clock
  logic        sys_rst = 1'h1; // Hardware reset
  pbc_straps_s strapPins;      // Configuration pins
  pbc_straps_s hwStraps;       // Pins seen at last hardware reset
  logic        wrEn;
  logic        rdEn;
  logic        rdValid_ff;
  logic        vld;
  logic [4:0]  regAddr;
  logic [15:0] wrData;
  logic [15:0] rdData_ff;
  logic [15:0] word;
  logic [15:0] shadow;         // Expected register image
  pbc_ctrl_s   ctrl_ff;
  int          fails = 0;
  int          num_checks = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  pbc_control_reg dut (.clk(clk), .sys_rst(sys_rst), .strapPins(strapPins), .wrEn(wrEn),
    .rdEn(rdEn), .regAddr(regAddr), .wrData(wrData), .rdData_ff(rdData_ff),
    .rdValid_ff(rdValid_ff), .ctrl_ff(ctrl_ff));
  pbc_station_model sta (.clk(clk), .wrEn(wrEn), .rdEn(rdEn), .regAddr(regAddr),
    .wrData(wrData), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff));

  // Register image holding only the pin-latched bits
  function automatic logic [15:0] strap_word(pbc_straps_s s);
    return {2'h0, s.speedLo, s.anEnable, s.powerDown, 2'h0, s.duplex, 8'h0};
  endfunction

  // Port controls implied by a register image, restart idle
  function automatic pbc_ctrl_s ctrl_of(logic [15:0] w);
    return pbc_ctrl_s'({w[14], w[13] & ~w[6], w[12], 1'h0, w[11], w[10], w[8]});
  endfunction

  // Hold reset 3 cycles with fresh random pins
  task automatic hw_reset();
    hwStraps = pbc_straps_s'(4'($urandom));
    strapPins = hwStraps;
    sys_rst = 1'h1;
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    @(posedge clk);
  endtask

  // Read back the word and compare it and the driven controls
  task automatic chk_reg(input logic [15:0] e);
    sta.rd(PbcCtrlAddr, word, vld);
    `CHK(vld, 1'h1)
    `CHK(word, e)
    `CHK(ctrl_ff, ctrl_of(e))
  endtask

  // Single place where the run ends
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(87));
    hw_reset();
    chk_reg(strap_word(hwStraps));
    // Random legal words; a stray write elsewhere must not land
    repeat (24)
    begin
      shadow = 16'($urandom) & 16'h7d00; // Speed high bit kept 0
      if (shadow[14])
        shadow[12] = 1'h0; // No negotiation in loopback
      sta.wr(PbcCtrlAddr, shadow);
      chk_reg(shadow);
      sta.wr(5'(($urandom % 31) + 1), ~shadow);
      sta.rd(5'(($urandom % 31) + 1), word, vld);
      `CHK(vld, 1'h1)
      `CHK(word, 16'h0)
      chk_reg(shadow);
    end
    // Restart: visible at once, then clears by itself
    sta.wr(PbcCtrlAddr, 16'h1200);
    sta.rd(PbcCtrlAddr, word, vld);
    `CHK(word, 16'h1200)
    `CHK(ctrl_ff.anRestart, 1'h1)
    repeat (8) @(posedge clk);
    chk_reg(16'h1000);
    // Soft reset with changed pins must restore the hardware-reset copy
    sta.wr(PbcCtrlAddr, 16'h0400 | (~strap_word(hwStraps) & 16'h3900));
    strapPins = ~hwStraps;
    // Reset word also sets isolate and flipped straps, so only a real restore passes
    sta.wr(PbcCtrlAddr, 16'h8400 | (~strap_word(hwStraps) & 16'h3900));
    repeat (4) @(posedge clk);
    chk_reg(strap_word(hwStraps));
    // Second hardware reset resamples the pins
    hw_reset();
    chk_reg(strap_word(hwStraps));
    tally_and_finish();
  end

  // Watchdog: the tests need roughly 280 cycles; 5000 cycles leaves a wide margin
  initial
  begin
    #50us;
    fails++;
    tally_and_finish();
  end
endmodule // testbench
`undef CHK
`default_nettype wire
